// *** shared/asr_pkg.sv ***
// package: timing constants and types of the static memory controller
package asr_pkg;
  localparam int ADDR_W = 15;
  localparam int DATA_W = 8;
  localparam int CLK_PERIOD_NS = 25;
  // least times, in ns
  localparam int CYCLE_MIN_NS = 55;
  localparam int ADDR_TO_DATA_DELAY_NS = 55;
  localparam int OE_TO_DATA_DELAY_NS = 30;
  localparam int ADDR_TO_WRITE_END_NS = 50;
  localparam int WRITE_PULSE_NS = 40;
  localparam int DATA_SETUP_TO_WRITE_END_NS = 25;
  localparam int OE_OFF_TO_FLOAT_DELAY_NS = 20;
  localparam int RETENTION_EXIT_WAIT_NS = 5000000;
  // cycle counts, least times rounded up, at least one
  function automatic int cyc_up(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction
  // two extra cycles for the data synchroniser
  localparam int READ_CYC = cyc_up(ADDR_TO_DATA_DELAY_NS) + 2;
  localparam int WRITE_CYC = cyc_up(ADDR_TO_WRITE_END_NS);
  localparam int FLOAT_CYC = cyc_up(OE_OFF_TO_FLOAT_DELAY_NS);
  localparam int RET_WAIT_CYC = cyc_up(RETENTION_EXIT_WAIT_NS);
  localparam int CNT_W = 8;
  localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
  typedef enum logic [4:0] {
    ASR_IDLE  = 5'b00001,
    ASR_READ  = 5'b00010,
    ASR_WRITE = 5'b00100,
    ASR_GAP   = 5'b01000,
    ASR_RET   = 5'b10000
  } asr_state_t;
endpackage

// *** shared/asr_sync_if.sv ***
// interface: synchronised pin data between the synchroniser and the controller
`timescale 1ns/1ps
interface asr_sync_if;
  logic [asr_pkg::DATA_W-1:0] data;
  modport src (output data);
  modport dst (input  data);
endinterface

// *** hw/asr_sync.sv ***
// two flip-flop synchroniser for the data pins
`timescale 1ns/1ps
module asr_sync (
  input  wire logic                       core_clk_i, // clock
  input  wire logic                       ce_i,       // clock enable
  input  wire logic [asr_pkg::DATA_W-1:0] pin_i,      // raw data pins
  asr_sync_if.src                         sync        // synchronised data
);
  import asr_pkg::*;
  logic [DATA_W-1:0] meta;
  logic [DATA_W-1:0] stab;
  logic [DATA_W-1:0] next_meta;
  logic [DATA_W-1:0] next_stab;
  always_comb begin
    next_meta = ce_i ? pin_i : meta;
    next_stab = ce_i ? meta : stab;
  end
  always_ff @(posedge core_clk_i) begin
    meta <= next_meta;
    stab <= next_stab;
  end
  assign sync.data = stab;
endmodule

// *** hw/asr_ctrl.sv ***
// host controller driving an asynchronous 32k x 8 static memory
`timescale 1ns/1ps
//------------------------------------------------------------
// Functional notes
//------------------------------------------------------------
// Functional notes
// - address valid at least 50 ns before write end
// - select low at least 50 ns before write end
// - write interval at least 40 ns
// - address valid no later than write start
// - address stable past the rising strobe edge
// - write data valid at least 25 ns before write end
// - write data held at least 0 ns after write end
// - host never drives bus while memory drives read data
// - select high before retention; wait 5 ms after retention
module asr_ctrl #(
  parameter int RET_WAIT = asr_pkg::RET_WAIT_CYC // retention exit wait, cycles
) (
  input  wire logic                       core_clk_i,  // 40 MHz clock
  input  wire logic                       rst_n_i,     // sync reset, active low
  input  wire logic                       ce_i,        // clock enable
  input  wire logic                       req_i,       // request pulse
  input  wire logic                       req_wr_i,    // 1 write, 0 read
  input  wire logic [asr_pkg::ADDR_W-1:0] req_addr_i,  // request address
  input  wire logic [asr_pkg::DATA_W-1:0] req_wdata_i, // write data
  input  wire logic                       ret_i,       // retention request level
  output logic                            ready_o,     // accepts a request
  output logic                            done_o,      // cycle finished pulse
  output logic      [asr_pkg::DATA_W-1:0] rdata_o,     // read data
  output logic      [asr_pkg::ADDR_W-1:0] word_addr_o, // memory address
  output logic                            cs_n_o,      // chip select, low
  output logic                            we_n_o,      // write strobe, low
  output logic                            oe_n_o,      // output enable, low
  output logic      [asr_pkg::DATA_W-1:0] byte_io_o,   // data pins out
  output logic                            byte_io_oe_o,// data pins drive
  input  wire logic [asr_pkg::DATA_W-1:0] byte_io_i    // data pins in
);
  import asr_pkg::*;
  if (RET_WAIT < 1) begin : g_bad_wait
    $error("RET_WAIT out of range");
  end
  if (READ_CYC >= 2**CNT_W || WRITE_CYC >= 2**CNT_W || FLOAT_CYC >= 2**CNT_W) begin : g_bad_cnt
    $error("counts too wide");
  end

  asr_sync_if sif ();
  asr_sync u_sync (
    .core_clk_i (core_clk_i),
    .ce_i       (ce_i),
    .pin_i      (byte_io_i),
    .sync       (sif.src)
  );

  //------------------------------------------------------------
  // state
  //------------------------------------------------------------
  asr_state_t        st;
  asr_state_t        next_st;
  logic [CNT_W-1:0]  cnt;
  logic [CNT_W-1:0]  next_cnt;
  logic [31:0]       rcnt;
  logic [31:0]       next_rcnt;
  logic              ret_wait;
  logic              next_ret_wait;
  logic              ready;
  logic              next_ready;
  logic              done;
  logic              next_done;
  logic [DATA_W-1:0] rdata;
  logic [DATA_W-1:0] next_rdata;
  logic [ADDR_W-1:0] addr;
  logic [ADDR_W-1:0] next_addr;
  logic              cs_n;
  logic              next_cs_n;
  logic              we_n;
  logic              next_we_n;
  logic              oe_n;
  logic              next_oe_n;
  logic [DATA_W-1:0] dout;
  logic [DATA_W-1:0] next_dout;
  logic              doe;
  logic              next_doe;

  always_comb begin
    next_st       = st;
    next_cnt      = cnt;
    next_rcnt     = rcnt;
    next_ret_wait = ret_wait;
    next_done     = 1'b0;
    next_rdata    = rdata;
    next_addr     = addr;
    next_cs_n     = cs_n;
    next_we_n     = we_n;
    next_oe_n     = oe_n;
    next_dout     = dout;
    next_doe      = doe;
    next_ready    = 1'b0;
    case (st)
      ASR_IDLE: begin
        if (ret_i) begin
          next_st   = ASR_RET;
          next_cs_n = 1'b1;
        end else if (ret_wait) begin
          if (rcnt <= 32'd1) begin
            next_ret_wait = 1'b0;
            next_ready    = 1'b1;
          end
          next_rcnt = rcnt - 32'd1;
        end else if (req_i && ready) begin
          next_addr = req_addr_i;
          next_cs_n = 1'b0;
          if (req_wr_i) begin
            next_st   = ASR_WRITE;
            next_we_n = 1'b0;
            next_dout = req_wdata_i;
            next_doe  = 1'b1;
            next_cnt  = 8'(WRITE_CYC);
          end else begin
            next_st   = ASR_READ;
            next_oe_n = 1'b0;
            next_cnt  = 8'(READ_CYC);
          end
        end else begin
          next_ready = 1'b1;
        end
      end
      ASR_WRITE: begin
        next_cnt = cnt - 8'h01;
        if (cnt == 8'h01) begin
          next_we_n = 1'b1;
          next_cs_n = 1'b1;
          next_st   = ASR_GAP;
          next_cnt  = 8'(FLOAT_CYC);
          next_done = 1'b1;
        end
      end
      ASR_READ: begin
        next_cnt = cnt - 8'h01;
        if (cnt == 8'h01) begin
          next_rdata = sif.data;
          next_oe_n  = 1'b1;
          next_cs_n  = 1'b1;
          next_st    = ASR_GAP;
          next_cnt   = 8'(FLOAT_CYC);
          next_done  = 1'b1;
        end
      end
      ASR_GAP: begin
        // address and data stay put while memory floats
        next_doe = 1'b0;
        next_cnt = cnt - 8'h01;
        if (cnt <= 8'h01) begin
          next_st    = ASR_IDLE;
          next_ready = !ret_i && !ret_wait;
        end
      end
      ASR_RET: begin
        next_cs_n = 1'b1;
        next_doe  = 1'b0;
        if (!ret_i) begin
          next_st       = ASR_IDLE;
          next_ret_wait = 1'b1;
          next_rcnt     = RET_WAIT;
        end
      end
      default: begin
        next_st = ASR_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      st       <= ASR_IDLE;
      cnt      <= CNT_ZERO;
      rcnt     <= 32'h0;
      ret_wait <= 1'b0;
      ready    <= 1'b0;
      done     <= 1'b0;
      rdata    <= 8'h00;
      addr     <= 15'h0000;
      cs_n     <= 1'b1;
      we_n     <= 1'b1;
      oe_n     <= 1'b1;
      dout     <= 8'h00;
      doe      <= 1'b0;
    end else if (ce_i) begin
      st       <= next_st;
      cnt      <= next_cnt;
      rcnt     <= next_rcnt;
      ret_wait <= next_ret_wait;
      ready    <= next_ready;
      done     <= next_done;
      rdata    <= next_rdata;
      addr     <= next_addr;
      cs_n     <= next_cs_n;
      we_n     <= next_we_n;
      oe_n     <= next_oe_n;
      dout     <= next_dout;
      doe      <= next_doe;
    end
  end

  assign ready_o      = ready;
  assign done_o       = done;
  assign rdata_o      = rdata;
  assign word_addr_o  = addr;
  assign cs_n_o       = cs_n;
  assign we_n_o       = we_n;
  assign oe_n_o       = oe_n;
  assign byte_io_o    = dout;
  assign byte_io_oe_o = doe;

  //------------------------------------------------------------
  // assertions
  //------------------------------------------------------------
  sequence s_wr_start;
    ce_i && $fell(we_n);
  endsequence
  sequence s_wr_hold;
    (!we_n && !cs_n && doe)[*2];
  endsequence

  a_no_contention: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    !(doe && !oe_n)) else $error("host drives bus during read");
  a_write_pulse: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    s_wr_start |-> s_wr_hold) else $error("write pulse too short");
  a_addr_stable_wr: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (!we_n && $past(!we_n)) |-> $stable(addr)) else $error("address moved");
  a_wr_we_cs: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    !we_n |-> !cs_n && oe_n) else $error("strobe without select");
  a_data_hold: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (ce_i && $rose(we_n)) |-> doe && $stable(dout)) else $error("data hold lost");
  a_addr_after_wr: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (ce_i && $rose(we_n)) |-> $stable(addr)) else $error("address not held");
  a_read_len: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (ce_i && $fell(oe_n)) |-> (!oe_n)[*5]) else $error("read too short");
  a_ret_cs: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    st == ASR_RET |-> cs_n && !doe) else $error("select low in retention");
  a_float_gap: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (ce_i && $rose(oe_n)) |-> !doe) else $error("drive right after read");
endmodule

// *** testbench/asr_mem_model.sv ***
// partner model: asynchronous 32k x 8 static memory
`timescale 1ns/1ps
module asr_mem_model #(
  parameter int SLOW_NS = 50 // slow read access, ns
) (
  input  wire logic [14:0] word_addr_i, // address pins
  input  wire logic        cs_n_i,      // chip select, low
  input  wire logic        we_n_i,      // write strobe, low
  input  wire logic        oe_n_i,      // output enable, low
  input  wire logic [7:0]  dq_i,        // data pins seen
  input  wire logic        slow_i,      // answer at the slow end
  output logic      [7:0]  dq_o,        // data pins driven
  output logic             dq_oe_o      // model drives the pins
);
  // no clock and no refresh
  logic [7:0] mem [0:32767];
  logic [7:0] rd_fast;
  logic [7:0] rd_slow;
  logic [7:0] last = 8'h00;
  logic       wr_on = 1'b0;
  // store at the earlier rising strobe edge
  always @(cs_n_i or we_n_i) begin
    if (wr_on && (cs_n_i || we_n_i)) mem[word_addr_i] = dq_i;
    wr_on = !cs_n_i && !we_n_i;
  end
  assign rd_fast = mem[word_addr_i];
  assign #(SLOW_NS) rd_slow = rd_fast;
  assign dq_oe_o = !cs_n_i && we_n_i && !oe_n_i;
  always @* if (dq_oe_o) last = slow_i ? rd_slow : rd_fast;
  // released pins show the inverse of the last value
  assign dq_o = dq_oe_o ? last : ~last;
endmodule

// *** testbench/test_async_static_ram_32k_x8.sv ***
// testbench: self-checking run of the static memory controller
`timescale 1ns/1ps
module test_async_static_ram_32k_x8;
  import asr_pkg::*;
  localparam int RET_W = 4;
  logic              core_clk_i = 0, rst_n_i = 0, ce_i = 1, req_i = 0, req_wr_i = 0;
  logic              ret_i = 0, slow = 0;
  logic [ADDR_W-1:0] req_addr_i = '0;
  logic [DATA_W-1:0] req_wdata_i = '0, q;
  wire               ready_o, done_o, cs_n_o, we_n_o, oe_n_o, byte_io_oe_o, mem_oe;
  wire  [DATA_W-1:0] rdata_o, byte_io_o, mem_dq, pin;
  wire  [ADDR_W-1:0] word_addr_o;
  int                bad_count = 0, samples_checked = 0, lat, n;
  logic [ADDR_W-1:0] av [4] = '{15'h0000, 15'h7FFF, 15'h1555, 15'h2AAA};
  logic [DATA_W-1:0] dv [4] = '{8'hA5, 8'h5A, 8'hFF, 8'h00};
  assign pin = byte_io_oe_o ? byte_io_o : mem_dq;
  always #12.5 core_clk_i = ~core_clk_i;
  asr_ctrl #(.RET_WAIT(RET_W)) i_dut (.core_clk_i, .rst_n_i, .ce_i, .req_i, .req_wr_i,
    .req_addr_i, .req_wdata_i, .ret_i, .ready_o, .done_o, .rdata_o, .word_addr_o,
    .cs_n_o, .we_n_o, .oe_n_o, .byte_io_o, .byte_io_oe_o, .byte_io_i(pin));
  asr_mem_model #(.SLOW_NS(ADDR_TO_DATA_DELAY_NS)) i_mem (.word_addr_i(word_addr_o),
    .cs_n_i(cs_n_o), .we_n_i(we_n_o),
    .oe_n_i(oe_n_o), .dq_i(pin), .slow_i(slow), .dq_o(mem_dq), .dq_oe_o(mem_oe));
  //--------------------------------------------------
  // shared tasks
  //--------------------------------------------------
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic op(logic wr, logic [ADDR_W-1:0] a, logic [DATA_W-1:0] d, logic poke,
                    logic stall);
    n = 0;
    while (ready_o !== 1'b1 && n < 20) begin
      @(posedge core_clk_i);
      #1 n++;
    end
    chk("ready_wait", ready_o, 1);
    @(posedge core_clk_i);
    req_i <= 1'b1;
    req_wr_i <= wr;
    req_addr_i <= a;
    req_wdata_i <= d;
    @(posedge core_clk_i);
    req_i <= 1'b0;
    lat = 0;
    while (done_o !== 1'b1 && lat < 20) begin
      @(posedge core_clk_i);
      // poke: a request while busy, must be ignored
      if (poke) begin
        req_i <= (lat == 0);
        req_addr_i <= a ^ 15'h0001;
        req_wdata_i <= ~d;
      end
      if (stall) ce_i <= (lat != 0);
      #1 lat++;
      if (lat == 1) begin
        chk("strobes", {cs_n_o, we_n_o, oe_n_o, byte_io_oe_o}, wr ? 4'h3 : 4'h4);
        chk("addr", word_addr_o, a);
        if (wr) chk("wdata", byte_io_o, d);
      end
    end
    chk("done_seen", done_o, 1);
    q = rdata_o;
    @(posedge core_clk_i);
    #1 chk("done_pulse", done_o, 0);
  endtask
  task automatic rd_chk(logic [ADDR_W-1:0] a, logic [DATA_W-1:0] d, int ex);
    op(0, a, d ^ 8'h0F, 0, ex != 0);
    chk("rd_data", q, d);
    chk("rd_lat", lat, READ_CYC + ex);
  endtask
  //--------------------------------------------------
  // scenarios
  //--------------------------------------------------
  task automatic t_reset;
    repeat (2) @(posedge core_clk_i);
    #1 chk("rst_out", {cs_n_o, we_n_o, oe_n_o, byte_io_oe_o, ready_o, done_o}, 6'h38);
    @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    @(posedge core_clk_i);
    #1 chk("rst_ready", ready_o, 1);
  endtask
  task automatic t_rw;
    for (int i = 0; i < 4; i++) begin
      op(1, av[i], dv[i], 0, 0);
      chk("wr_lat", lat, WRITE_CYC);
    end
    for (int i = 0; i < 4; i++) rd_chk(av[i], dv[i], 0);
  endtask
  task automatic t_refused;
    op(1, 15'h0010, 8'h66, 0, 0);
    op(1, 15'h0011, 8'hC3, 1, 0);
    chk("wr_lat_busy", lat, WRITE_CYC);
    rd_chk(15'h0010, 8'h66, 0);
    rd_chk(15'h0011, 8'hC3, 0);
  endtask
  task automatic t_stall;
    op(1, 15'h4321, 8'h81, 0, 1);
    chk("wr_lat_stall", lat, WRITE_CYC + 1);
    rd_chk(15'h4321, 8'h81, 1);
  endtask
  task automatic t_slow;
    @(posedge core_clk_i);
    slow <= 1'b1;
    rd_chk(av[2], dv[2], 0);
    rd_chk(av[3], dv[3], 0);
    @(posedge core_clk_i);
    slow <= 1'b0;
  endtask
  task automatic t_ret;
    @(posedge core_clk_i);
    ret_i <= 1'b1;
    repeat (3) @(posedge core_clk_i);
    #1 chk("ret_state", {ready_o, cs_n_o}, 2'b01);
    @(posedge core_clk_i);
    ret_i <= 1'b0;
    n = 0;
    while (ready_o !== 1'b1 && n < 20) begin
      @(posedge core_clk_i);
      #1 n++;
    end
    chk("ret_wait", n, RET_W + 1);
    rd_chk(av[1], dv[1], 0);
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge core_clk_i)
    if (byte_io_oe_o === 1'b1 && mem_oe === 1'b1) chk("bus_clash", 1, 0);
  initial begin
    repeat (3000) @(posedge core_clk_i);
    bad_count++;
    results();
  end
  initial begin
    t_reset();
    t_rw();
    t_refused();
    t_stall();
    t_slow();
    t_ret();
    results();
  end
endmodule
